// ---- verilog/uwl_params.svh ----
// Register map, field positions, reset values and frame sizes for the serial channel
`ifndef UWL_PARAMS_SVH
`define UWL_PARAMS_SVH
`define UWL_A_RATE      3'h0
`define UWL_A_LINE      3'h1
`define UWL_A_STAT      3'h2
`define UWL_A_DATA      3'h3
`define UWL_A_MCFG      3'h4
`define UWL_RATE_W      13
`define UWL_RATE_RST    13'h0004
`define UWL_LINE_RST    16'h0000
`define UWL_MCFG_RST    16'h0000
`define UWL_STAT_RST    5'h18
`define UWL_LC_BRK      0
`define UWL_LC_TXON     1
`define UWL_LC_RXON     2
`define UWL_LC_SLEEP    3
`define UWL_LC_WAKE     4
`define UWL_LC_ILT      5
`define UWL_LC_M9       6
`define UWL_LC_LOOP     7
`define UWL_ST_RXF      0
`define UWL_ST_IDLE     1
`define UWL_ST_OVR      2
`define UWL_ST_TXD      3
`define UWL_ST_TXE      4
`define UWL_MC_PRIO_HI  3
`define UWL_MC_STOP     15
`define UWL_FRAME8      4'hA
`define UWL_FRAME9      4'hB
`define UWL_H_CMD       8'h00
`define UWL_H_RESULT    8'h04
`define UWL_H_SEND      8'h08
`define UWL_H_SCFG      8'h0C
`define UWL_H_RD_BIT    31
`define UWL_H_BUSY_BIT  31
`endif

// ---- verilog/uwl_pkg.sv ----
// Shared types of the serial channel and its controller
package uwl_pkg;
   typedef enum logic [0:0] {
      UWL_RX_IDLE = 1'b0,
      UWL_RX_BITS = 1'b1
   } uwl_rx_state_type;
   typedef enum logic [1:0] {
      UWL_ACC_IDLE  = 2'b00,
      UWL_ACC_PULSE = 2'b01,
      UWL_ACC_WAIT  = 2'b10
   } uwl_acc_state_type;
endpackage

// ---- verilog/uwl_if.sv ----
// Register port and serial line joining the channel and its controller
interface uwl_if;
   logic [2:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic        line_rxd;
   logic        line_txd;
   modport device (input reg_addr, input reg_wr, input reg_rd, input reg_wdata, output reg_rdata,
                   input line_rxd, output line_txd);
   modport host (output reg_addr, output reg_wr, output reg_rd, output reg_wdata, input reg_rdata,
                 output line_rxd, input line_txd);
endinterface

// ---- verilog/uwl_device.sv ----
// Serial channel: receiver with wake-up, idle detection, loopback and transmitter
//
// Operation
// - Sleeping receiver updates no status flags
// - Software writes sleep flag; hardware clears on wake
// - Wake select: 0 idle-line, 1 address-mark
// - Idle line while asleep clears sleep
// - Address mark frame clears sleep
// - Waking frame is received normally
// - Software may re-set sleep on foreign address
// - Remote leaves idle frame between messages
// - Remote starts each message with address frame
// - Address mark tolerates gaps, costs one bit
// - Loopback feeds receiver, holds pin at mark
// - Software enables both ends before loopback
// - Idle after reset until initialised
// - Status read then data write clears tx flags
// - Software sets nonzero priority, clears stop
// - Rate divisor and 8/9-bit frame select
// - Send break left clear for normal sending
// - Idle line is frame-size run of ones
// - Idle kind: short counts stop, long after
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`include "uwl_params.svh"
module uwl_device
   import uwl_pkg::*;
(
   input  wire logic    hclk,
   input  wire logic    hresetn,
   input  wire logic    ce,
   uwl_if.device        link,
   output logic         asleep,
   output logic         rx_full,
   output logic         tx_busy
);
   logic [`UWL_RATE_W-1:0] rate_q;
   logic [15:0]            line_q;
   logic [15:0]            mcfg_q;
   logic [4:0]             stat_q;
   logic [8:0]             rx_hold_q;
   logic [8:0]             tx_hold_q;
   logic [15:0]            rdata_q;
   logic                   rx_arm_q;
   logic                   tx_arm_q;
   logic                   idle_arm_q;
   logic                   sync1_q;
   logic                   sync2_q;
   logic                   txd_q;
   logic                   tx_line_q;
   logic [10:0]            tsh_q;
   logic [3:0]             tcnt_q;
   logic [`UWL_RATE_W-1:0] ttim_q;
   logic                   txon_d1_q;
   uwl_rx_state_type       rst_q;
   logic [`UWL_RATE_W-1:0] rtim_q;
   logic [3:0]             rcnt_q;
   logic [8:0]             rsh_q;
   logic [3:0]             ones_q;
   logic                   active;
   logic                   rx_src;
   logic                   m9;
   logic [3:0]             fsize;
   logic                   tick;
   logic                   frame_done;
   logic [8:0]             rx_word;
   logic                   msb;
   logic                   idle_hit;
   logic                   wake_addr;
   logic                   wake_idle;
   logic                   flags_ok;
   logic                   wr_line;
   logic                   wr_data;
   logic                   rd_stat;
   logic                   rd_data;
   logic                   tx_load;

   // Nothing runs until software has given a priority and released stop
   assign active   = ~mcfg_q[`UWL_MC_STOP] && (mcfg_q[`UWL_MC_PRIO_HI:0] != 4'h0);
   assign m9       = line_q[`UWL_LC_M9];
   assign fsize    = m9 ? `UWL_FRAME9 : `UWL_FRAME8;
   assign rx_src   = line_q[`UWL_LC_LOOP] ? tx_line_q : sync2_q;
   assign wr_line  = link.reg_wr && (link.reg_addr == `UWL_A_LINE);
   assign wr_data  = link.reg_wr && (link.reg_addr == `UWL_A_DATA);
   assign rd_stat  = link.reg_rd && (link.reg_addr == `UWL_A_STAT);
   assign rd_data  = link.reg_rd && (link.reg_addr == `UWL_A_DATA);
   assign tick     = (rtim_q == '0);
   assign frame_done = (rst_q == UWL_RX_BITS) && tick && (rcnt_q == fsize - 4'h1);
   assign rx_word  = m9 ? rsh_q : {1'b0, rsh_q[8:1]};
   assign msb      = m9 ? rsh_q[8] : rsh_q[8];
   assign wake_addr = frame_done && line_q[`UWL_LC_SLEEP] && line_q[`UWL_LC_WAKE] && msb;
   assign idle_hit = tick && rx_src && (ones_q == fsize - 4'h1);
   assign wake_idle = idle_hit && line_q[`UWL_LC_SLEEP] && ~line_q[`UWL_LC_WAKE];
   // The waking frame itself counts as an ordinary one
   assign flags_ok = ~line_q[`UWL_LC_SLEEP] || wake_addr;
   // Held back during preamble and break so pending data is not dropped
   assign tx_load  = active && line_q[`UWL_LC_TXON] && txon_d1_q && ~line_q[`UWL_LC_BRK] && (tcnt_q == 4'h0)
                     && ~stat_q[`UWL_ST_TXE];

   assign asleep   = line_q[`UWL_LC_SLEEP];
   assign rx_full  = stat_q[`UWL_ST_RXF];
   assign tx_busy  = ~stat_q[`UWL_ST_TXD];
   assign link.reg_rdata = rdata_q;
   assign link.line_txd  = txd_q;

   // Line input from the far station is asynchronous
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
      end else if (ce) begin
         sync1_q <= link.line_rxd;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rate_q <= `UWL_RATE_RST;
         mcfg_q <= `UWL_MCFG_RST;
      end else if (ce && link.reg_wr) begin
         if (link.reg_addr == `UWL_A_RATE) begin
            rate_q <= link.reg_wdata[`UWL_RATE_W-1:0];
         end
         if (link.reg_addr == `UWL_A_MCFG) begin
            mcfg_q <= link.reg_wdata;
         end
      end
   end

   // Hardware wake beats a software write landing in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_q <= `UWL_LINE_RST;
      end else if (ce) begin
         if (wr_line) begin
            line_q <= link.reg_wdata;
         end
         if (wake_addr || wake_idle) begin
            line_q[`UWL_LC_SLEEP] <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 16'h0000;
      end else if (ce && link.reg_rd) begin
         unique case (link.reg_addr)
            `UWL_A_RATE: rdata_q <= {3'h0, rate_q};
            `UWL_A_LINE: rdata_q <= line_q;
            `UWL_A_STAT: rdata_q <= {11'h000, stat_q};
            `UWL_A_DATA: rdata_q <= {7'h00, rx_hold_q};
            `UWL_A_MCFG: rdata_q <= mcfg_q;
            default:     rdata_q <= 16'h0000;
         endcase
      end
   end

   // Status flags: a set in the same cycle as a clear always wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_q     <= `UWL_STAT_RST;
         rx_arm_q   <= 1'b0;
         tx_arm_q   <= 1'b0;
         idle_arm_q <= 1'b0;
         rx_hold_q  <= 9'h000;
         tx_hold_q  <= 9'h000;
      end else if (ce) begin
         if (rd_stat) begin
            rx_arm_q <= 1'b1;
            tx_arm_q <= stat_q[`UWL_ST_TXD];
         end
         if (rd_data && rx_arm_q) begin
            stat_q[`UWL_ST_RXF]  <= 1'b0;
            stat_q[`UWL_ST_IDLE] <= 1'b0;
            stat_q[`UWL_ST_OVR]  <= 1'b0;
            rx_arm_q             <= 1'b0;
         end
         if (wr_data) begin
            tx_hold_q <= link.reg_wdata[8:0];
            if (tx_arm_q) begin
               stat_q[`UWL_ST_TXE] <= 1'b0;
               stat_q[`UWL_ST_TXD] <= 1'b0;
               tx_arm_q            <= 1'b0;
            end
         end
         if (tx_load) begin
            stat_q[`UWL_ST_TXE] <= 1'b1;
         end
         if ((tcnt_q == 4'h1) && (ttim_q == '0)) begin
            stat_q[`UWL_ST_TXD] <= 1'b1;
         end
         if (frame_done && flags_ok) begin
            if (stat_q[`UWL_ST_RXF] && !(rd_data && rx_arm_q)) begin
               stat_q[`UWL_ST_OVR] <= 1'b1;
            end else begin
               rx_hold_q           <= rx_word;
               stat_q[`UWL_ST_RXF] <= 1'b1;
               idle_arm_q          <= 1'b1;
            end
         end
         // Re-armed only by a received frame, so long idle flags once
         if (idle_hit && idle_arm_q && !line_q[`UWL_LC_SLEEP]) begin
            stat_q[`UWL_ST_IDLE] <= 1'b1;
            idle_arm_q           <= 1'b0;
         end
      end
   end

   // Transmitter: preamble on enable, break frames, else data frames
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tsh_q     <= 11'h7FF;
         tcnt_q    <= 4'h0;
         ttim_q    <= '0;
         tx_line_q <= 1'b1;
         txd_q     <= 1'b1;
         txon_d1_q <= 1'b0;
      end else if (ce) begin
         txon_d1_q <= line_q[`UWL_LC_TXON] && active;
         txd_q     <= line_q[`UWL_LC_LOOP] ? 1'b1 : tx_line_q;
         if (tcnt_q != 4'h0) begin
            if (ttim_q == '0) begin
               ttim_q    <= rate_q;
               tcnt_q    <= tcnt_q - 4'h1;
               tx_line_q <= (tcnt_q == 4'h1) ? 1'b1 : tsh_q[0];
               tsh_q     <= {1'b1, tsh_q[10:1]};
            end else begin
               ttim_q <= ttim_q - 1'b1;
            end
         end else if (active && line_q[`UWL_LC_TXON]) begin
            ttim_q <= rate_q;
            if (!txon_d1_q) begin
               tcnt_q <= fsize + 4'h1;
               tsh_q  <= 11'h7FF;
            end else if (line_q[`UWL_LC_BRK]) begin
               tcnt_q <= fsize + 4'h1;
               tsh_q  <= 11'h000;
            end else if (tx_load) begin
               tcnt_q <= fsize + 4'h1;
               tsh_q  <= m9 ? {1'b1, tx_hold_q, 1'b0} : {2'b11, tx_hold_q[7:0], 1'b0};
            end
         end
      end
   end

   // Receiver: bit timer free-runs while idle so ones are still counted
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_q  <= UWL_RX_IDLE;
         rtim_q <= '0;
         rcnt_q <= 4'h0;
         rsh_q  <= 9'h000;
         ones_q <= 4'h0;
      end else if (ce) begin
         if (!(active && line_q[`UWL_LC_RXON])) begin
            rst_q  <= UWL_RX_IDLE;
            rtim_q <= rate_q;
            ones_q <= 4'h0;
         end else begin
            rtim_q <= tick ? rate_q : rtim_q - 1'b1;
            if (tick) begin
               if (!rx_src) begin
                  ones_q <= 4'h0;
               // Saturate even when a shorter frame size is chosen later
               end else if (ones_q < fsize) begin
                  ones_q <= ones_q + 4'h1;
               end
            end
            unique case (rst_q)
               UWL_RX_IDLE: begin
                  if (!rx_src) begin
                     rst_q  <= UWL_RX_BITS;
                     rcnt_q <= 4'h0;
                     rtim_q <= {1'b0, rate_q[`UWL_RATE_W-1:1]};
                  end
               end
               UWL_RX_BITS: begin
                  if (tick) begin
                     rcnt_q <= rcnt_q + 4'h1;
                     // Long detection ignores ones inside the frame
                     if (line_q[`UWL_LC_ILT]) begin
                        ones_q <= 4'h0;
                     end
                     if ((rcnt_q == 4'h0) && rx_src) begin
                        rst_q <= UWL_RX_IDLE;
                     end else if (frame_done) begin
                        rst_q <= UWL_RX_IDLE;
                     end else if (rcnt_q != 4'h0) begin
                        rsh_q <= {rx_src, rsh_q[8:1]};
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule

// ---- verilog/uwl_host.sv ----
// Controller: AHB-Lite slave that drives the channel registers and acts as remote station
`include "uwl_params.svh"
module uwl_host
   import uwl_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   uwl_if.host              link
);
   logic                   hreadyout_q;
   logic [31:0]            hrdata_q;
   logic                   dwr_q;
   logic [7:0]             daddr_q;
   uwl_acc_state_type      acc_q;
   logic                   rd_q;
   logic                   reg_wr_q;
   logic                   reg_rd_q;
   logic [2:0]             reg_addr_q;
   logic [15:0]            reg_wdata_q;
   logic [15:0]            result_q;
   logic [`UWL_RATE_W:0]   scfg_q;
   logic [10:0]            ssh_q;
   logic [3:0]             scnt_q;
   logic [`UWL_RATE_W-1:0] stim_q;
   logic                   sline_q;
   logic                   addr_ph;
   logic                   wr_cmd;
   logic                   wr_send;

   assign addr_ph = hsel && hready && htrans[1];
   assign wr_cmd  = dwr_q && (daddr_q == `UWL_H_CMD) && (acc_q == UWL_ACC_IDLE);
   assign wr_send = dwr_q && (daddr_q == `UWL_H_SEND) && (scnt_q == 4'h0);

   assign hreadyout      = hreadyout_q;
   assign hresp          = 1'b0;
   assign hrdata         = hrdata_q;
   assign link.reg_wr    = reg_wr_q;
   assign link.reg_rd    = reg_rd_q;
   assign link.reg_addr  = reg_addr_q;
   assign link.reg_wdata = reg_wdata_q;
   assign link.line_rxd  = sline_q;

   // Zero-wait slave; write data is taken in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         hrdata_q    <= 32'h0000_0000;
         dwr_q       <= 1'b0;
         daddr_q     <= 8'h00;
         scfg_q      <= '0;
      end else if (ce) begin
         dwr_q <= addr_ph && hwrite;
         if (addr_ph) begin
            daddr_q <= haddr[7:0];
         end
         if (addr_ph && !hwrite) begin
            unique case (haddr[7:0])
               `UWL_H_RESULT: hrdata_q <= {acc_q != UWL_ACC_IDLE, 15'h0000, result_q};
               `UWL_H_SEND:   hrdata_q <= {scnt_q != 4'h0, 31'h0000_0000};
               `UWL_H_SCFG:   hrdata_q <= {18'h0_0000, scfg_q};
               default:       hrdata_q <= 32'h0000_0000;
            endcase
         end
         if (dwr_q && (daddr_q == `UWL_H_SCFG)) begin
            scfg_q <= hwdata[`UWL_RATE_W:0];
         end
      end
   end

   // One register access to the channel at a time
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_q       <= UWL_ACC_IDLE;
         rd_q        <= 1'b0;
         reg_wr_q    <= 1'b0;
         reg_rd_q    <= 1'b0;
         reg_addr_q  <= 3'h0;
         reg_wdata_q <= 16'h0000;
         result_q    <= 16'h0000;
      end else if (ce) begin
         unique case (acc_q)
            UWL_ACC_IDLE: begin
               if (wr_cmd) begin
                  acc_q       <= UWL_ACC_PULSE;
                  rd_q        <= hwdata[`UWL_H_RD_BIT];
                  reg_rd_q    <= hwdata[`UWL_H_RD_BIT];
                  reg_wr_q    <= ~hwdata[`UWL_H_RD_BIT];
                  reg_addr_q  <= hwdata[18:16];
                  reg_wdata_q <= hwdata[15:0];
               end
            end
            UWL_ACC_PULSE: begin
               reg_wr_q <= 1'b0;
               reg_rd_q <= 1'b0;
               acc_q    <= UWL_ACC_WAIT;
            end
            UWL_ACC_WAIT: begin
               if (rd_q) begin
                  result_q <= link.reg_rdata;
               end
               acc_q <= UWL_ACC_IDLE;
            end
            default: acc_q <= UWL_ACC_IDLE;
         endcase
      end
   end

   // Remote station: message spacing and address marks are up to software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ssh_q   <= 11'h7FF;
         scnt_q  <= 4'h0;
         stim_q  <= '0;
         sline_q <= 1'b1;
      end else if (ce) begin
         if (scnt_q != 4'h0) begin
            if (stim_q == '0) begin
               stim_q  <= scfg_q[`UWL_RATE_W-1:0];
               scnt_q  <= scnt_q - 4'h1;
               sline_q <= (scnt_q == 4'h1) ? 1'b1 : ssh_q[0];
               ssh_q   <= {1'b1, ssh_q[10:1]};
            end else begin
               stim_q <= stim_q - 1'b1;
            end
         end else if (wr_send) begin
            stim_q <= scfg_q[`UWL_RATE_W-1:0];
            scnt_q <= (scfg_q[`UWL_RATE_W] ? `UWL_FRAME9 : `UWL_FRAME8) + 4'h1;
            ssh_q  <= scfg_q[`UWL_RATE_W] ? {1'b1, hwdata[8:0], 1'b0} : {2'b11, hwdata[7:0], 1'b0};
         end
      end
   end
endmodule

// ---- tb/uwl_link_asserts.sv ----
// Checker on the link between the serial channel and its controller
`include "uwl_params.svh"
module uwl_link_asserts (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic [2:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        line_rxd,
   input wire logic        line_txd,
   input wire logic        asleep,
   input wire logic        rx_full
);
   logic on_q;
   logic loop_q;
   logic mark_q;
   logic lwr;

   assign lwr = reg_wr && reg_addr == `UWL_A_LINE;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Shadow of the loopback and wake select bits, plus a sticky flag set by the first transmitter enable, from the writes seen on the link
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         on_q   <= 1'b0;
         loop_q <= 1'b0;
         mark_q <= 1'b0;
      end else if (lwr) begin
         on_q   <= on_q | reg_wdata[`UWL_LC_TXON];
         loop_q <= reg_wdata[`UWL_LC_LOOP];
         mark_q <= reg_wdata[`UWL_LC_WAKE];
      end
   end

   AST_SLEEP_QUIET: assert property (asleep && $past(asleep) |-> !$rose(rx_full))
      else $error("rx_full rose while asleep");
   AST_SLEEP_SET: assert property (lwr && reg_wdata[`UWL_LC_SLEEP] |=> asleep)
      else $error("sleep write not taken");
   AST_SLEEP_CLR: assert property (lwr && !reg_wdata[`UWL_LC_SLEEP] |=> !asleep)
      else $error("sleep clear write not taken");
   AST_WAKE_FULL: assert property ($fell(asleep) && mark_q && !$past(reg_wr) |-> ##[0:4] rx_full)
      else $error("waking frame not held");
   // Registered pin may finish its last bit in the cycle the loop starts
   AST_LOOP_MARK: assert property (loop_q && $past(loop_q) |-> line_txd)
      else $error("pin left mark in loopback");
   AST_QUIET_START: assert property (!on_q |-> line_txd)
      else $error("pin active before transmitter on");
   // Bench runs four clocks per bit
   AST_START_BIT: assert property ($fell(line_rxd) |-> (!line_rxd) [*4])
      else $error("start bit shorter than a bit time");
   AST_ACCESS_GAP: assert property (reg_wr || reg_rd |=> (!(reg_wr || reg_rd)) [*2])
      else $error("link accesses too close");
   AST_ACCESS_EXCL: assert property (!(reg_wr && reg_rd))
      else $error("read and write pulses together");
   AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
endmodule

// ---- tb/uwl_receiver_wakeup_loopback_tb.sv ----
// Self-checking bench: controller drives the serial channel over the link
`include "uwl_params.svh"
module uwl_receiver_wakeup_loopback_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, asleep, rx_full, tx_busy;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, seed, r, x;
   logic [15:0] lc;
   logic [8:0]  d;
   int          num_errors, n_compared, cyc;

   uwl_if i_uwl_if ();
   uwl_device i_uwl_device (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(i_uwl_if.device), .asleep(asleep),
      .rx_full(rx_full), .tx_busy(tx_busy));
   uwl_host i_uwl_host (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .link(i_uwl_if.host));
   uwl_link_asserts i_uwl_link_asserts (.hclk(hclk), .hresetn(hresetn), .reg_addr(i_uwl_if.reg_addr),
      .reg_wr(i_uwl_if.reg_wr), .reg_rd(i_uwl_if.reg_rd), .reg_wdata(i_uwl_if.reg_wdata),
      .reg_rdata(i_uwl_if.reg_rdata), .line_rxd(i_uwl_if.line_rxd), .line_txd(i_uwl_if.line_txd),
      .asleep(asleep), .rx_full(rx_full));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         $display("FAIL %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dat);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h00_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= dat;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   // Channel register access through the controller, result left in r
   task automatic dev(input logic rd, input logic [2:0] a, input logic [15:0] dat);
      ahb(1'b1, `UWL_H_CMD, {rd, 12'h000, a, dat});
      do ahb(1'b0, `UWL_H_RESULT, 32'h0000_0000); while (r[31] !== 1'b0);
   endtask

   task automatic send(input logic [8:0] dat);
      ahb(1'b1, `UWL_H_SEND, {23'h00_0000, dat});
      do ahb(1'b0, `UWL_H_SEND, 32'h0000_0000); while (r[31] !== 1'b0);
   endtask

   task automatic wf(input logic which, input logic v, input string n);
      for (int i = 0; i < 600 && (which ? asleep : rx_full) !== v; i++) @(posedge hclk);
      chk(n, v, which ? asleep : rx_full);
   endtask

   // Status then data read, which also clears the receive flags
   task automatic rxchk(input logic [8:0] e, input logic m9);
      dev(1'b1, `UWL_A_STAT, 16'h0000);
      dev(1'b1, `UWL_A_DATA, 16'h0000);
      chk("rx data", {7'h00, e}, r[15:0] & (m9 ? 16'h01FF : 16'h00FF));
      chk("rx_full cleared", 0, rx_full);
   endtask

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         $display("FAIL run length expected 20000 seen %0d", cyc);
         test_done();
      end
   end

   initial begin
      seed = 32'ha1e0_80f0;
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      num_errors = 0;
      n_compared = 0;
      cyc = 0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      dev(1'b1, `UWL_A_RATE, 16'h0000);
      chk("rate reset", `UWL_RATE_RST, r[15:0]);
      dev(1'b1, `UWL_A_STAT, 16'h0000);
      chk("status reset", 16'h0018, r[15:0] & 16'h001F);
      chk("txd idle", 1, i_uwl_if.line_txd);
      chk("hresp okay", 0, hresp);
      $display("test reset done");
      dev(1'b0, `UWL_A_MCFG, 16'h0001);
      dev(1'b0, `UWL_A_RATE, 16'h0003);
      for (int m = 0; m < 2; m++) begin
         lc = 16'h0016;
         lc[`UWL_LC_M9] = m[0];
         ahb(1'b1, `UWL_H_SCFG, {18'h0_0000, m[0], 13'h0003});
         dev(1'b0, `UWL_A_LINE, lc | 16'h0008);
         chk("asleep set", 1, asleep);
         x = xs();
         send({1'b0, m[0], x[6:0]});
         repeat (20) @(posedge hclk);
         chk("asleep kept", 1, asleep);
         chk("no rx while asleep", 0, rx_full);
         d = m ? {1'b1, x[15:8]} : {2'b01, x[14:8]};
         send(d);
         wf(1'b1, 1'b0, "woken by mark");
         wf(1'b0, 1'b1, "mark frame held");
         rxchk(d, m[0]);
         dev(1'b0, `UWL_A_LINE, lc | 16'h0008);
         chk("back asleep", 1, asleep);
         $display("test address mark done, nine bit %0d", m);
      end
      ahb(1'b1, `UWL_H_SCFG, 32'h0000_0003);
      for (int k = 0; k < 2; k++) begin
         lc = 16'h0006;
         lc[`UWL_LC_ILT] = k[0];
         // Line must already count as idle, else the run in progress wakes it early
         repeat (60) @(posedge hclk);
         dev(1'b0, `UWL_A_LINE, lc | 16'h0008);
         x = xs();
         send({1'b0, x[7:0]});
         wf(1'b1, 1'b0, "woken by idle line");
         send({1'b0, x[15:8]});
         wf(1'b0, 1'b1, "first frame held");
         rxchk({1'b0, x[15:8]}, 1'b0);
         $display("test idle wake done, long idle %0d", k);
      end
      dev(1'b0, `UWL_A_LINE, 16'h0006);
      dev(1'b0, `UWL_A_LINE, 16'h0086);
      x = xs();
      dev(1'b1, `UWL_A_STAT, 16'h0000);
      chk("tx done before", 1, r[`UWL_ST_TXD]);
      dev(1'b0, `UWL_A_DATA, {8'h00, x[7:0]});
      chk("tx busy", 1, tx_busy);
      dev(1'b1, `UWL_A_STAT, 16'h0000);
      chk("tx done cleared", 0, r[`UWL_ST_TXD]);
      wf(1'b0, 1'b1, "loop frame held");
      rxchk({1'b0, x[7:0]}, 1'b0);
      chk("pin at mark", 1, i_uwl_if.line_txd);
      $display("test loopback done");
      dev(1'b0, `UWL_A_LINE, 16'h0007);
      repeat (8) @(posedge hclk);
      chk("break on pin", 0, i_uwl_if.line_txd);
      dev(1'b0, `UWL_A_LINE, 16'h0006);
      $display("test break done");
      test_done();
   end
endmodule
